// ---- src/seg_map_pkg.sv ----
`default_nettype none
package seg_map_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  // Register byte offsets on the APB slave.
  localparam logic [11:0] OFF_CTRL       = 12'h000;
  localparam logic [11:0] OFF_STATUS     = 12'h004;
  localparam logic [11:0] OFF_SOP        = 12'h008;
  localparam logic [11:0] OFF_FETCH_LO   = 12'h00c;
  localparam logic [11:0] OFF_FETCH_HI   = 12'h010;
  localparam logic [11:0] OFF_DESC_LO    = 12'h014;
  localparam logic [11:0] OFF_DESC_HI    = 12'h018;
  localparam logic [11:0] OFF_SELLO_LO   = 12'h01c;
  localparam logic [11:0] OFF_SELLO_HI   = 12'h020;
  localparam logic [11:0] OFF_SELHI_LO   = 12'h024;
  localparam logic [11:0] OFF_SELHI_HI   = 12'h028;
  localparam logic [11:0] OFF_REF        = 12'h02c;
  localparam logic [11:0] OFF_EA         = 12'h030;
  localparam logic [11:0] OFF_RAW_LO     = 12'h034;
  localparam logic [11:0] OFF_RAW_HI     = 12'h038;
  localparam logic [11:0] OFF_DPL_CPL    = 12'h03c;
  localparam logic [11:0] OFF_GR_BASE    = 12'h100;
  // Control register bits (write-one pulses plus sticky mode).
  localparam int unsigned CTRL_ENTER     = 0;
  localparam int unsigned CTRL_EXIT      = 1;
  localparam int unsigned CTRL_FETCH     = 2;
  localparam int unsigned CTRL_MEMREF    = 3;
  localparam int unsigned CTRL_SEGLOAD   = 4;
  localparam int unsigned CTRL_WIDE_OPS  = 5;
  // Status register bits.
  localparam int unsigned ST_LEGACY      = 0;
  localparam int unsigned ST_GP_FAULT    = 1;
  localparam int unsigned ST_SS_FAULT    = 2;
  localparam int unsigned ST_OP32        = 3;
  // Descriptor field positions.
  localparam int unsigned D_BASE_LSB     = 0;
  localparam int unsigned D_LIM_LSB      = 32;
  localparam int unsigned D_TYPE_LSB     = 52;
  localparam int unsigned D_NONSYS       = 56;
  localparam int unsigned D_DPL_LSB      = 57;
  localparam int unsigned D_PRESENT      = 59;
  localparam int unsigned D_SW_SPARE     = 60;
  localparam int unsigned D_RSV_SPARE    = 61;
  localparam int unsigned D_SIZE         = 62;
  localparam int unsigned D_GRAN         = 63;
  localparam int unsigned TYPE_EXPDOWN   = 2;
  localparam logic [11:0] GRAN_FILL      = 12'hfff;
  localparam logic [63:0] RESET_64       = 64'h0;
endpackage
`default_nettype wire

// ---- src/legacy_segment_address_map.sv ----
// The address map and the APB interface to the registers were left to the implementer.
`default_nettype none
module legacy_segment_address_map
  import seg_map_pkg::*;
#(
  parameter int unsigned NUM_GR = 8
) (
  // Clock and reset.
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // APB slave.
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [seg_map_pkg::ADDR_W-1:0] paddr,
  input  wire logic [seg_map_pkg::DATA_W-1:0] pwdata,
  output logic [seg_map_pkg::DATA_W-1:0] prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Fault events.
  output logic                           general_protection_fault,
  output logic                           stack_segment_fault,
  // Fetch pointer.
  output logic [63:0]                    linear_fetch_pointer
);
  import seg_map_pkg::*;

  logic [63:0] gr_ff [NUM_GR];
  logic [31:0] legacy_ff [NUM_GR];
  logic [63:0] code_descriptor_reg_ff;
  logic [63:0] selector_pack_low_ff;
  logic [63:0] selector_pack_high_ff;
  logic [63:0] raw_desc_ff;
  logic [31:0] segment_offset_pointer_ff;
  logic [31:0] ea_ff;
  logic [2:0]  ref_sel_ff;
  logic [3:0]  dpl_cpl_ff;
  logic        legacy_ff_mode;
  logic        gp_ff;
  logic        ss_ff;
  logic        wide_ops_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        gpo_ff;
  logic        sso_ff;
  logic [63:0] lfp_ff;

  logic        acc;
  logic        wr;
  logic        gr_hit;
  logic [2:0]  gr_idx;
  logic        ctl_enter;
  logic        ctl_exit;
  logic        ctl_fetch;
  logic        ctl_memref;
  logic        ctl_segload;
  logic [63:0] nxt_unscr;
  logic [31:0] code_limit;
  logic [31:0] data_limit;
  logic [31:0] ea_eff;
  logic        fetch_fault;
  logic        lim_fault;
  logic        priv_fault;
  logic [63:0] ref_desc;

  // Access phase of APB; one wait state, so pready comes one cycle after the access phase starts.
  assign acc    = psel & penable & ~pready_ff;
  assign wr     = acc & pwrite;
  assign gr_hit = (paddr >= OFF_GR_BASE) && (paddr < OFF_GR_BASE + 12'(NUM_GR * 8));
  assign gr_idx = 3'((paddr - OFF_GR_BASE) >> 3);
  assign ctl_enter   = wr && paddr == OFF_CTRL && pwdata[CTRL_ENTER];
  assign ctl_exit    = wr && paddr == OFF_CTRL && pwdata[CTRL_EXIT];
  assign ctl_fetch   = wr && paddr == OFF_CTRL && pwdata[CTRL_FETCH];
  assign ctl_memref  = wr && paddr == OFF_CTRL && pwdata[CTRL_MEMREF];
  assign ctl_segload = wr && paddr == OFF_CTRL && pwdata[CTRL_SEGLOAD];

  // Unscramble a memory-format descriptor into the register layout.
  always_comb begin
    nxt_unscr = {raw_desc_ff[55], raw_desc_ff[54], raw_desc_ff[53], raw_desc_ff[52],
                 raw_desc_ff[47], raw_desc_ff[46:45], raw_desc_ff[44], raw_desc_ff[43:40],
                 raw_desc_ff[51:48], raw_desc_ff[15:0],
                 raw_desc_ff[63:56], raw_desc_ff[39:16]};
  end

  // Limits scaled by granularity; native references never pass through here.
  always_comb begin
    code_limit = code_descriptor_reg_ff[D_GRAN]
               ? {code_descriptor_reg_ff[51:32], GRAN_FILL}
               : {12'h000, code_descriptor_reg_ff[51:32]};
    fetch_fault = segment_offset_pointer_ff > code_limit;
  end

  // Pick the segment used by a data reference: 0..3 data, 4 code, 5 stack.
  always_comb begin
    ref_desc = RESET_64;
    case (ref_sel_ff)
      3'h4:    ref_desc = code_descriptor_reg_ff;
      3'h5:    ref_desc = gr_ff[1];
      // Widen before adding so that slots 2 and 3 reach registers 4 and 5.
      default: ref_desc = gr_ff[3'(ref_sel_ff[1:0]) + 3'h2];
    endcase
  end

  // Data reference checks. Descriptor slots share the integer file for compactness.
  always_comb begin
    data_limit = ref_desc[D_GRAN] ? {ref_desc[51:32], GRAN_FILL}
                                  : {12'h000, ref_desc[51:32]};
    ea_eff = ref_desc[D_SIZE] ? ea_ff : {16'h0000, ea_ff[15:0]};
    if (ref_desc[D_NONSYS] && !ref_desc[D_TYPE_LSB + 3] && ref_desc[D_TYPE_LSB + TYPE_EXPDOWN])
      lim_fault = ea_eff <= data_limit;
    else
      lim_fault = ea_eff > data_limit;
    priv_fault = ref_desc[58:57] < dpl_cpl_ff[1:0];
    if (!ref_desc[D_NONSYS])
      priv_fault = 1'b1;
  end

  // Legacy mode and fault status; a new fault outranks a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      legacy_ff_mode <= 1'b0;
      gp_ff          <= 1'b0;
      ss_ff          <= 1'b0;
      wide_ops_ff    <= 1'b0;
    end else begin
      if (ctl_enter)
        legacy_ff_mode <= 1'b1;
      else if (ctl_exit)
        legacy_ff_mode <= 1'b0;
      if (wr && paddr == OFF_CTRL)
        wide_ops_ff <= pwdata[CTRL_WIDE_OPS];
      if (wr && paddr == OFF_STATUS) begin
        if (pwdata[ST_GP_FAULT])
          gp_ff <= 1'b0;
        if (pwdata[ST_SS_FAULT])
          ss_ff <= 1'b0;
      end
      if (ctl_fetch && legacy_ff_mode && fetch_fault)
        gp_ff <= 1'b1;
      if (ctl_memref && legacy_ff_mode) begin
        if (!ref_desc[D_PRESENT] && ref_sel_ff == 3'h5)
          ss_ff <= 1'b1;
        else if (!ref_desc[D_PRESENT] || lim_fault || priv_fault)
          gp_ff <= 1'b1;
      end
    end
  end

  // Fault pulses and fetch pointer outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpo_ff <= 1'b0;
      sso_ff <= 1'b0;
      lfp_ff <= RESET_64;
    end else begin
      gpo_ff <= (ctl_fetch && legacy_ff_mode && fetch_fault)
             || (ctl_memref && legacy_ff_mode && ref_desc[D_PRESENT]
                 && (lim_fault || priv_fault))
             || (ctl_memref && legacy_ff_mode && !ref_desc[D_PRESENT] && ref_sel_ff != 3'h5);
      sso_ff <= ctl_memref && legacy_ff_mode && !ref_desc[D_PRESENT] && ref_sel_ff == 3'h5;
      if (ctl_fetch && legacy_ff_mode)
        lfp_ff <= {32'h0000_0000, segment_offset_pointer_ff + code_descriptor_reg_ff[31:0]};
    end
  end

  // Descriptor, selector and pointer registers written by native code or a segment load.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_descriptor_reg_ff    <= RESET_64;
      selector_pack_low_ff      <= RESET_64;
      selector_pack_high_ff     <= RESET_64;
      raw_desc_ff               <= RESET_64;
      segment_offset_pointer_ff <= 32'h0000_0000;
      ea_ff                     <= 32'h0000_0000;
      ref_sel_ff                <= 3'h0;
      dpl_cpl_ff                <= 4'h0;
    end else begin
      if (wr && paddr == OFF_DESC_LO)
        code_descriptor_reg_ff[31:0] <= pwdata;
      // both spare bits kept with wide ops
      if (wr && paddr == OFF_DESC_HI)
        code_descriptor_reg_ff[63:32] <= wide_ops_ff ? pwdata
                                       : {pwdata[31:30], 2'b00, pwdata[27:0]};
      if (ctl_segload)
        code_descriptor_reg_ff <= nxt_unscr;
      if (wr && paddr == OFF_SELLO_LO)
        selector_pack_low_ff[31:0] <= pwdata;
      if (wr && paddr == OFF_SELLO_HI)
        selector_pack_low_ff[63:32] <= pwdata;
      if (wr && paddr == OFF_SELHI_LO)
        selector_pack_high_ff[31:0] <= pwdata;
      if (wr && paddr == OFF_SELHI_HI)
        selector_pack_high_ff[63:32] <= pwdata;
      if (wr && paddr == OFF_RAW_LO)
        raw_desc_ff[31:0] <= pwdata;
      if (wr && paddr == OFF_RAW_HI)
        raw_desc_ff[63:32] <= pwdata;
      if (wr && paddr == OFF_SOP)
        segment_offset_pointer_ff <= pwdata;
      else if (ctl_fetch && legacy_ff_mode && !fetch_fault)
        segment_offset_pointer_ff <= segment_offset_pointer_ff + 32'h0000_0001;
      if (wr && paddr == OFF_EA)
        ea_ff <= pwdata;
      if (wr && paddr == OFF_REF)
        ref_sel_ff <= pwdata[2:0];
      if (wr && paddr == OFF_DPL_CPL)
        dpl_cpl_ff <= pwdata[3:0];
    end
  end

  // Integer register file: legacy view latches low halves on entry, exit sign-extends.
  // physical slot indexing
  for (genvar i = 0; i < NUM_GR; i++) begin : g_gr
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        gr_ff[i]     <= RESET_64;
        legacy_ff[i] <= 32'h0000_0000;
      end else begin
        if (ctl_enter)
          legacy_ff[i] <= gr_ff[i][31:0];
        if (ctl_exit)
          gr_ff[i] <= {{32{legacy_ff[i][31]}}, legacy_ff[i]};
        else if (wr && gr_hit && gr_idx == 3'(i)) begin
          if (!paddr[2])
            gr_ff[i][31:0] <= pwdata;
          else
            gr_ff[i][63:32] <= pwdata;
        end
        if (legacy_ff_mode && wr && gr_hit && gr_idx == 3'(i) && !paddr[2])
          legacy_ff[i] <= pwdata;
      end
    end
  end

  // APB answer: one access cycle; unmapped reads, and writes above OFF_DPL_CPL outside the integer file, return error and zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= acc;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      if (acc && !pwrite) begin
        case (paddr)
          OFF_CTRL:     prdata_ff <= {26'h0, wide_ops_ff, 5'h0};
          OFF_STATUS:   prdata_ff <= {28'h0, code_descriptor_reg_ff[D_SIZE], ss_ff, gp_ff,
                                      legacy_ff_mode};
          OFF_SOP:      prdata_ff <= segment_offset_pointer_ff;
          OFF_FETCH_LO: prdata_ff <= lfp_ff[31:0];
          OFF_FETCH_HI: prdata_ff <= lfp_ff[63:32];
          OFF_DESC_LO:  prdata_ff <= code_descriptor_reg_ff[31:0];
          OFF_DESC_HI:  prdata_ff <= code_descriptor_reg_ff[63:32];
          OFF_SELLO_LO: prdata_ff <= selector_pack_low_ff[31:0];
          OFF_SELLO_HI: prdata_ff <= selector_pack_low_ff[63:32];
          OFF_SELHI_LO: prdata_ff <= selector_pack_high_ff[31:0];
          OFF_SELHI_HI: prdata_ff <= selector_pack_high_ff[63:32];
          OFF_REF:      prdata_ff <= {29'h0, ref_sel_ff};
          OFF_EA:       prdata_ff <= ea_ff;
          OFF_RAW_LO:   prdata_ff <= raw_desc_ff[31:0];
          OFF_RAW_HI:   prdata_ff <= raw_desc_ff[63:32];
          OFF_DPL_CPL:  prdata_ff <= {28'h0, dpl_cpl_ff};
          default: begin
            if (gr_hit)
              prdata_ff <= paddr[2] ? gr_ff[gr_idx][63:32] : gr_ff[gr_idx][31:0];
            else
              pslverr_ff <= 1'b1;
          end
        endcase
      end else if (acc && !gr_hit && paddr > OFF_DPL_CPL) begin
        pslverr_ff <= 1'b1;
      end
    end
  end

  assign prdata                   = prdata_ff;
  assign pready                   = pready_ff;
  assign pslverr                  = pslverr_ff;
  assign general_protection_fault = gpo_ff;
  assign stack_segment_fault      = sso_ff;
  assign linear_fetch_pointer     = lfp_ff;
endmodule
`default_nettype wire

// ---- bench/seg_map_properties.sv ----
`default_nettype none
// Watches the APB answer timing, the fault pulses and the fetch pointer.
module seg_map_properties
  import seg_map_pkg::*;
(
  // Clock and reset.
  input wire logic                           pclk,
  input wire logic                           presetn,
  // APB slave side.
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic                           pwrite,
  input wire logic [seg_map_pkg::ADDR_W-1:0] paddr,
  input wire logic [seg_map_pkg::DATA_W-1:0] pwdata,
  input wire logic [seg_map_pkg::DATA_W-1:0] prdata,
  input wire logic                           pready,
  input wire logic                           pslverr,
  // Events and pointer.
  input wire logic                           general_protection_fault,
  input wire logic                           stack_segment_fault,
  input wire logic [63:0]                    linear_fetch_pointer
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_done_ff;
  // Events are only legal just after a write, so remember the edge that takes each one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wr_done_ff <= 1'b0;
    else wr_done_ff <= psel && penable && !pready && pwrite;
  end
  property p_one_wait; psel && penable && !pready |=> pready; endproperty
  a_one_wait: assert property (p_one_wait) else $error("access answer late");
  property p_ready_once; pready |=> !pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("pready too long");
  property p_idle_data; !pready |-> prdata == 32'h0; endproperty
  a_idle_data: assert property (p_idle_data) else $error("prdata not zero");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr alone");
  property p_ptr_high; linear_fetch_pointer[63:32] == 32'h0; endproperty
  a_ptr_high: assert property (p_ptr_high) else $error("pointer high half set");
  property p_ptr_cause;
    $changed(linear_fetch_pointer) |-> wr_done_ff || $past(wr_done_ff);
  endproperty
  a_ptr_cause: assert property (p_ptr_cause) else $error("pointer moved alone");
  property p_gp_pulse; general_protection_fault |=> !general_protection_fault; endproperty
  a_gp_pulse: assert property (p_gp_pulse) else $error("gp fault too long");
  property p_ss_pulse; stack_segment_fault |=> !stack_segment_fault; endproperty
  a_ss_pulse: assert property (p_ss_pulse) else $error("stack fault too long");
  property p_fault_cause;
    general_protection_fault || stack_segment_fault |-> wr_done_ff || $past(wr_done_ff);
  endproperty
  a_fault_cause: assert property (p_fault_cause) else $error("fault with no command");
  property p_one_fault; !(general_protection_fault && stack_segment_fault); endproperty
  a_one_fault: assert property (p_one_fault) else $error("both faults at once");
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import seg_map_pkg::*;
  typedef struct {logic [31:0] v; logic e;} note_t;
  // Reference cases: descriptor high word, address, {cpl, slot, status}.
  localparam logic [31:0] RH [11] = '{32'h4930_0010, 32'h4930_0010, 32'h4130_0010,
    32'h4130_0010, 32'h4930_0010, 32'h4970_0010, 32'h4970_0010, 32'h0930_0010,
    32'hc930_0001, 32'h4f30_0010, 32'h4830_0010};
  localparam logic [31:0] RE [11] = '{32'h10, 32'h11, 32'h10, 32'h10, 32'h10, 32'h10,
    32'h11, 32'h1_0005, 32'h1fff, 32'h10, 32'h10};
  localparam logic [7:0] RC [11] = '{8'h01, 8'h0b, 8'h1b, 8'h2d, 8'hc3, 8'h03, 8'h01,
    8'h01, 8'h01, 8'h01, 8'h03};
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic              wide = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              gpf;
  logic              ssf;
  logic [63:0]       lfp;
  note_t             nt;
  note_t             q[$];
  int                fail_count = 0;
  int                total_checks = 0;
  int                gp_seen = 0;
  int                ss_seen = 0;
  always #2 pclk = ~pclk;
  // Fault pulses last one cycle, so count them as they pass.
  always @(posedge pclk) begin
    if (gpf === 1'b1) gp_seen++;
    if (ssf === 1'b1) ss_seen++;
  end
  legacy_segment_address_map dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .general_protection_fault(gpf),
    .stack_segment_fault(ssf), .linear_fetch_pointer(lfp));
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One APB transfer; the request holds until pready is sampled high.
  task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  // The note goes in first so the watcher always finds it.
  task automatic rd(logic [11:0] a, logic [31:0] e, logic err = 1'b0);
    q.push_back('{e, err});
    xfer(1'b0, a, 32'h0);
  endtask
  // Command pulses keep the wide option at its chosen level.
  task automatic cmd(int b);
    wr(OFF_CTRL, (32'h1 << b) | (32'(wide) << CTRL_WIDE_OPS));
  endtask
  function automatic logic [31:0] dhi(logic g, logic d, logic [3:0] ty, logic [19:0] lim);
    return {g, d, 2'b00, 1'b1, 2'b00, 1'b1, ty, lim};
  endfunction
  // Each read answer is compared with the oldest note.
  always @(posedge pclk) begin
    if (pready === 1'b1 && pwrite === 1'b0) begin
      nt = q.pop_front();
      check("prdata", prdata, nt.v);
      check("pslverr", {31'h0, pslverr}, {31'h0, nt.e});
    end
  end
  // Cuts a hang short well beyond the roughly seven hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    results();
  end
  initial begin
    logic [31:0] gv [8];
    logic [31:0] h;
    logic [31:0] base;
    logic [31:0] sop;
    logic [7:0]  c;
    int          gi;
    int          g0;
    int          s0;
    void'($urandom(32'h1640));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Junk high halves must not survive a pass through legacy mode.
    for (int i = 0; i < 8; i++) begin
      gv[i] = $urandom;
      gv[i][31] = i[0];
      wr(OFF_GR_BASE + 12'(8 * i), gv[i]);
      wr(OFF_GR_BASE + 12'(8 * i + 4), $urandom);
    end
    // frames kept in gv before entry.
    cmd(CTRL_ENTER);
    cmd(CTRL_EXIT);
    for (int i = 0; i < 8; i++) begin
      rd(OFF_GR_BASE + 12'(8 * i), gv[i]);
      rd(OFF_GR_BASE + 12'(8 * i + 4), {32{gv[i][31]}});
    end
    $display("test integer map finished");
    for (int i = 0; i < 4; i++) begin
      h = $urandom;
      wr(OFF_SELLO_LO + 12'(4 * i), h);
      rd(OFF_SELLO_LO + 12'(4 * i), h);
    end
    rd(12'h200, 32'h0, 1'b1);
    // Spare bits drop without the wide option and stay with it.
    h = dhi(1'b1, 1'b1, 4'h0, 20'habcde) | 32'h3000_0000;
    for (int k = 0; k < 2; k++) begin
      wide = k[0];
      wr(OFF_CTRL, 32'(wide) << CTRL_WIDE_OPS);
      wr(OFF_DESC_HI, h);
      rd(OFF_DESC_HI, wide ? h : h & 32'hcfff_ffff);
    end
    // A segment load rebuilds the register layout from the memory layout.
    wr(OFF_RAW_LO, 32'h5678_bcde);
    wr(OFF_RAW_HI, 32'h12da_da34);
    cmd(CTRL_SEGLOAD);
    rd(OFF_DESC_LO, 32'h1234_5678);
    rd(OFF_DESC_HI, 32'hddaa_bcde);
    $display("test selectors and spares finished");
    // The base is high enough that base plus offset wraps.
    base = $urandom | 32'hf000_0000;
    sop = 32'h2000_0000;
    wr(OFF_DESC_LO, base);
    wr(OFF_DESC_HI, dhi(1'b1, 1'b1, 4'hb, 20'hfffff));
    wr(OFF_SOP, sop);
    cmd(CTRL_ENTER);
    cmd(CTRL_FETCH);
    cmd(CTRL_FETCH);
    rd(OFF_FETCH_LO, base + sop + 32'h1);
    rd(OFF_FETCH_HI, 32'h0);
    check("fetch pointer", lfp[31:0], base + sop + 32'h1);
    // Offsets at and just past the limit, plain and scaled.
    for (int k = 0; k < 4; k++) begin
      wr(OFF_DESC_HI, dhi(k[1], 1'b1, 4'hb, k[1] ? 20'h1 : 20'h10));
      wr(OFF_SOP, (k[1] ? 32'h1fff : 32'h10) + 32'(k[0]));
      g0 = gp_seen;
      cmd(CTRL_FETCH);
      rd(OFF_STATUS, {28'h0, 1'b1, 1'b0, k[0], 1'b1});
      check("gp pulse", 32'(gp_seen - g0), 32'(k[0]));
      wr(OFF_STATUS, 32'h6);
    end
    wr(OFF_DESC_HI, dhi(1'b0, 1'b0, 4'hb, 20'h10));
    rd(OFF_STATUS, 32'h1);
    $display("test fetch finished");
    // Limit, absence, privilege, expansion, size and scaling on data; absence on stack.
    for (int k = 0; k < 11; k++) begin
      c = RC[k];
      gi = (c[5:3] == 3'd5) ? 1 : 32'(c[5:3]) + 2;
      wr(OFF_GR_BASE + 12'(8 * gi), 32'h0);
      wr(OFF_GR_BASE + 12'(8 * gi + 4), RH[k]);
      wr(OFF_EA, RE[k]);
      wr(OFF_DPL_CPL, 32'(c[7:6]));
      wr(OFF_REF, 32'(c[5:3]));
      g0 = gp_seen;
      s0 = ss_seen;
      cmd(CTRL_MEMREF);
      rd(OFF_STATUS, 32'(c[2:0]));
      check("gp pulse", 32'(gp_seen - g0), 32'(c[1]));
      check("ss pulse", 32'(ss_seen - s0), 32'(c[2]));
      wr(OFF_STATUS, 32'h6);
    end
    $display("test references finished");
    results();
  end
endmodule
bind legacy_segment_address_map seg_map_properties chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .general_protection_fault(general_protection_fault),
  .stack_segment_fault(stack_segment_fault), .linear_fetch_pointer(linear_fetch_pointer));
`default_nettype wire
